// [src/rtcb_top.sv]
// rtcb_top: circular buffer pointer engine for remote terminal subaddresses.
// assumes a protocol engine on mclk that hands over a completed message,
// a shared ram port with a level request held until ack, and a wishbone
// master for the config registers.
// Functional notes
// - mode 1 buffer limit raises message interrupt
// - mode 1 ignores broadcast segregation setting
// - info word broadcast flag shows broadcast status
// - broadcast transmit: no bus reply, pointer kept
// - mode 1 advance pointer, wrap past end
// - mode 2 when pingpong off, circular two on
// - mode 2 splits data and info, resets
// - transmit and receive use separate descriptors
// - descriptor is four words from base N
// - fourth word addresses next info word in mode 2, buffer end in mode 1
// - mode 2 info at pointer, tag after
// - failed messages keep info pointer unchanged
// - good receive data stored from current pointer
// - info pointer advances by two per good message
// - plus one all ones: restore both pointers
`timescale 1ns/1ps

module rtcb_top
	import rtcb_pkg::*;
#(
	parameter int MAX_WORDS = rtcb_pkg::RTCB_MAX_WORDS
)
(
	input wire logic mclk, // device clock, 40 MHz
	input wire logic srst, // synchronous reset, active high
	input wire logic msg_valid, // completed message pulse
	input wire rtcb_pkg::rtcb_msg_t msg_in, // completed message details
	input wire logic rx_word_valid, // received data word strobe
	input wire logic [rtcb_pkg::RTCB_DW-1:0] rx_word, // received data word
	output rtcb_pkg::rtcb_ram_req_t ram_req, // shared ram request
	input wire logic ram_ack, // shared ram ack
	input wire logic [rtcb_pkg::RTCB_DW-1:0] ram_rdata, // shared ram read data
	output logic busy, // sequencer busy
	output logic tx_inhibit, // suppress bus transmit
	output rtcb_pkg::rtcb_result_t result, // message outcome pulse
	output logic message_interrupt_output, // interrupt pulse
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [3:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte select
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o // wishbone ack
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (MAX_WORDS < 1 || MAX_WORDS > RTCB_MAX_WORDS)
	begin : g_bad_depth
		$error("rtcb_top: MAX_WORDS out of range");
	end

	localparam int IW = $clog2(RTCB_MAX_WORDS + 1);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	rtcb_state_t state_q, state_d;
	rtcb_msg_t msg_q;
	rtcb_ram_req_t req_q;
	logic [RTCB_DW-1:0] ctrl_q, start_q, cur_q, w4_q;
	logic [RTCB_DW-1:0] rx_mem [MAX_WORDS];
	logic [IW-1:0] rx_cnt_q;
	logic [IW-1:0] wr_idx_q;
	logic [1:0] cfg_q;
	logic [15:0] good_cnt_q;
	logic mode2_q, wrap_q;
	logic [31:0] last_ptr_q;
	logic busy_q, tx_inh_q, irq_q;
	rtcb_result_t res_q;
	logic ack_q;
	logic [31:0] dat_q;

	// ----------------------------------------------------------------
	// message classification
	// ----------------------------------------------------------------
	wire logic cw_pp = ctrl_q[RTCB_CW_PP];
	wire logic cw_c1 = ctrl_q[RTCB_CW_CIR1];
	wire logic cw_c2 = ctrl_q[RTCB_CW_CIR2];
	// buffer select bit is don't care here, circular one only for mode 1
	wire logic is_mode2 = !cw_pp && cw_c2;
	wire logic is_mode1 = !cw_pp && !cw_c2 && cw_c1;
	wire logic [3:0] cw_code = ctrl_q[RTCB_CW_CODE_HI:RTCB_CW_CODE_LO];
	// broadcast transmit gets no reply and leaves pointers alone
	wire logic broadcast_flag_tx = msg_q.is_tx && msg_q.is_broadcast;
	wire logic msg_good = !(msg_q.msg_error || msg_q.busy_status ||
		msg_q.illegal || broadcast_flag_tx);

	// ----------------------------------------------------------------
	// pointer arithmetic
	// ----------------------------------------------------------------
	wire logic [RTCB_AW-1:0] cur_a = cur_q[RTCB_AW-1:0];
	wire logic [RTCB_AW-1:0] w4_a = w4_q[RTCB_AW-1:0];
	wire logic [RTCB_AW-1:0] start_a = start_q[RTCB_AW-1:0];
	wire logic [RTCB_AW-1:0] wc_a = RTCB_AW'(msg_q.word_count);
	// the same buffer serves broadcast and plain receive data
	wire logic [RTCB_AW-1:0] info_ptr = is_mode2 ? w4_a : cur_a;
	wire logic [RTCB_AW-1:0] data_base =
		is_mode2 ? cur_a : cur_a + RTCB_M1_DATA_OFS;
	wire logic [RTCB_AW-1:0] data_end = data_base + wc_a;
	wire logic m1_wrap = msg_good && (data_end > w4_a);
	wire logic [RTCB_AW-1:0] code_mask =
		(RTCB_AW'(1) << cw_code) - RTCB_AW'(1);
	wire logic [RTCB_AW-1:0] w4_inc = w4_a + RTCB_AW'(1);
	wire logic m2_full =
		msg_good && ((w4_inc & code_mask) == code_mask);
	// only the circular modes may wrap or interrupt
	wire logic wrap_now = is_mode2 ? m2_full : is_mode1 && m1_wrap;
	wire logic [RTCB_AW-1:0] new_cur =
		!msg_good ? cur_a :
		wrap_now ? start_a :
		data_end;
	wire logic [RTCB_AW-1:0] new_w4 =
		!msg_good ? w4_a :
		m2_full ? (w4_a & ~code_mask) :
		w4_a + RTCB_M2_INFO_STEP;
	// broadcast flag forced from the command's own status
	wire logic [RTCB_DW-1:0] info_out = {
		msg_q.info_word[RTCB_DW-1:RTCB_INFO_BROADCAST_FLAG_BIT+1],
		msg_q.is_broadcast,
		msg_q.info_word[RTCB_INFO_BROADCAST_FLAG_BIT-1:0]};
	wire logic store_data = !msg_q.is_tx && msg_good &&
		(msg_q.word_count != '0);
	wire logic last_data = (RTCB_AW'(wr_idx_q) + RTCB_AW'(1)) == wc_a;

	// ----------------------------------------------------------------
	// ram access per state
	// ----------------------------------------------------------------
	// descriptor words at N..N+3, one block per subaddress direction
	wire logic on_cur = state_q == RTCB_RD_CUR || state_q == RTCB_WR_CUR;
	wire logic on_w4 = state_q == RTCB_RD_W4 || state_q == RTCB_WR_W4;
	wire logic [RTCB_AW-1:0] desc_ofs =
		state_q == RTCB_RD_START ? RTCB_DESC_START :
		on_cur ? RTCB_DESC_CUR :
		on_w4 ? RTCB_DESC_W4 :
		RTCB_DESC_CTRL;
	wire logic [RTCB_AW-1:0] data_addr = data_base + RTCB_AW'(wr_idx_q);
	wire logic [RTCB_AW-1:0] acc_addr =
		state_q == RTCB_WR_INFO ? info_ptr :
		state_q == RTCB_WR_TAG ? info_ptr + RTCB_TAG_OFS :
		state_q == RTCB_WR_DATA ? data_addr :
		msg_q.desc_addr + desc_ofs;
	wire logic acc_we = state_q == RTCB_WR_INFO ||
		state_q == RTCB_WR_TAG || state_q == RTCB_WR_DATA ||
		state_q == RTCB_WR_CUR || state_q == RTCB_WR_W4;
	wire logic [RTCB_DW-1:0] data_word =
		rx_mem[wr_idx_q[$clog2(MAX_WORDS+1)-1:0] % MAX_WORDS];
	wire logic [RTCB_DW-1:0] acc_wdata =
		state_q == RTCB_WR_INFO ? info_out :
		state_q == RTCB_WR_TAG ? msg_q.time_tag :
		state_q == RTCB_WR_DATA ? data_word :
		state_q == RTCB_WR_CUR ? RTCB_DW'(new_cur) :
		state_q == RTCB_WR_W4 ? RTCB_DW'(new_w4) : '0;

	wire logic acc_state = !(state_q == RTCB_IDLE || state_q == RTCB_DONE);
	wire logic acc_done = req_q.valid && ram_ack;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			RTCB_IDLE: if (msg_valid) state_d = RTCB_RD_CTRL;
			RTCB_RD_CTRL: if (acc_done) state_d = RTCB_RD_START;
			RTCB_RD_START: if (acc_done) state_d = RTCB_RD_CUR;
			RTCB_RD_CUR: if (acc_done) state_d = RTCB_RD_W4;
			RTCB_RD_W4:
				if (acc_done)
					state_d = (is_mode1 || is_mode2) ? RTCB_WR_INFO :
						RTCB_DONE;
			RTCB_WR_INFO: if (acc_done) state_d = RTCB_WR_TAG;
			RTCB_WR_TAG:
				if (acc_done)
					state_d = store_data ? RTCB_WR_DATA :
						msg_good ? RTCB_WR_CUR : RTCB_DONE;
			RTCB_WR_DATA:
				if (acc_done && last_data) state_d = RTCB_WR_CUR;
			RTCB_WR_CUR:
				if (acc_done)
					state_d = is_mode2 ? RTCB_WR_W4 : RTCB_DONE;
			RTCB_WR_W4: if (acc_done) state_d = RTCB_DONE;
			RTCB_DONE: state_d = RTCB_IDLE;
			default: state_d = RTCB_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// sequencer registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst)
			state_q <= RTCB_IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			msg_q <= '0;
		else if (state_q == RTCB_IDLE && msg_valid)
			msg_q <= msg_in;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			ctrl_q <= '0;
			start_q <= '0;
			cur_q <= '0;
			w4_q <= '0;
		end
		else if (acc_done && !req_q.we)
		begin
			if (state_q == RTCB_RD_CTRL) ctrl_q <= ram_rdata;
			if (state_q == RTCB_RD_START) start_q <= ram_rdata;
			if (state_q == RTCB_RD_CUR) cur_q <= ram_rdata;
			if (state_q == RTCB_RD_W4) w4_q <= ram_rdata;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			req_q <= '0;
		else if (acc_done)
			req_q.valid <= 1'b0;
		else if (acc_state && !req_q.valid)
			req_q <= '{valid: 1'b1, we: acc_we, addr: acc_addr,
				wdata: acc_wdata};
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			wr_idx_q <= '0;
		else if (state_q == RTCB_WR_DATA && acc_done)
			wr_idx_q <= wr_idx_q + IW'(1);
		else if (state_q == RTCB_DONE)
			wr_idx_q <= '0;
	end

	// ----------------------------------------------------------------
	// receive word holding store, drained after completion
	// ----------------------------------------------------------------
	wire logic rx_take = rx_word_valid && state_q == RTCB_IDLE &&
		rx_cnt_q < IW'(MAX_WORDS);
	always_ff @(posedge mclk)
	begin
		if (srst)
			rx_cnt_q <= '0;
		else if (state_q == RTCB_DONE)
			rx_cnt_q <= '0;
		else if (rx_take)
			rx_cnt_q <= rx_cnt_q + IW'(1);
	end

	always_ff @(posedge mclk)
	begin
		if (rx_take)
			rx_mem[rx_cnt_q[$clog2(MAX_WORDS+1)-1:0] % MAX_WORDS] <= rx_word;
	end

	// ----------------------------------------------------------------
	// outcome, interrupt and status
	// ----------------------------------------------------------------
	wire logic finish = state_q == RTCB_DONE;
	wire logic irq_now = finish && wrap_now &&
		ctrl_q[RTCB_CW_LIMIT_IRQ] && cfg_q[RTCB_CFG_LIMIT_IRQ];
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			res_q <= '0;
			irq_q <= 1'b0;
			busy_q <= 1'b0;
			tx_inh_q <= 1'b0;
		end
		else
		begin
			res_q <= '{done: finish, good: finish && msg_good,
				wrapped: finish && wrap_now,
				unsupported: finish && !is_mode1 && !is_mode2};
			irq_q <= irq_now;
			busy_q <= state_d != RTCB_IDLE;
			tx_inh_q <= (state_d != RTCB_IDLE) &&
				(state_q == RTCB_IDLE ? (msg_in.is_tx &&
				msg_in.is_broadcast) : broadcast_flag_tx);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			good_cnt_q <= '0;
			mode2_q <= 1'b0;
			wrap_q <= 1'b0;
			last_ptr_q <= '0;
		end
		else if (finish)
		begin
			if (msg_good) good_cnt_q <= good_cnt_q + 16'h0001;
			mode2_q <= is_mode2;
			wrap_q <= wrap_now;
			last_ptr_q <= {RTCB_DW'(new_cur), RTCB_DW'(new_w4)};
		end
	end

	// ----------------------------------------------------------------
	// wishbone slave, one wait state, unmapped reads zero
	// ----------------------------------------------------------------
	wire logic wb_req = wb_cyc_i && wb_stb_i && !ack_q;
	wire logic [31:0] status_word = {good_cnt_q, 13'h0, wrap_q,
		mode2_q, busy_q};
	wire logic [31:0] rd_word =
		wb_adr_i == RTCB_REG_CONFIG ? {30'h0, cfg_q} :
		wb_adr_i == RTCB_REG_STATUS ? status_word :
		wb_adr_i == RTCB_REG_LAST_PTR ? last_ptr_q : 32'h00000000;
	wire logic cfg_wr = wb_req && wb_we_i && wb_sel_i[0] &&
		wb_adr_i == RTCB_REG_CONFIG;
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			ack_q <= 1'b0;
			dat_q <= '0;
			cfg_q <= RTCB_CONFIG_RST;
		end
		else
		begin
			ack_q <= wb_req;
			dat_q <= wb_req && !wb_we_i ? rd_word : 32'h00000000;
			if (cfg_wr) cfg_q <= wb_dat_i[1:0];
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign ram_req = req_q;
	assign busy = busy_q;
	assign tx_inhibit = tx_inh_q;
	assign result = res_q;
	assign message_interrupt_output = irq_q;
	assign wb_dat_o = dat_q;
	assign wb_ack_o = ack_q;

endmodule

// [src/rtcb_pkg.sv]
// rtcb_pkg: constants, states and carriers of the circular buffer engine.
// assumes one device clock and 16-bit shared ram words.
package rtcb_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int RTCB_AW = 15;
	localparam int RTCB_DW = 16;
	localparam int RTCB_WCW = 6;
	localparam int RTCB_MAX_WORDS = 32;

	// ----------------------------------------------------------------
	// descriptor block layout, word offsets from its base
	// ----------------------------------------------------------------
	localparam logic [RTCB_AW-1:0] RTCB_DESC_CTRL = 15'h0000;
	localparam logic [RTCB_AW-1:0] RTCB_DESC_START = 15'h0001;
	localparam logic [RTCB_AW-1:0] RTCB_DESC_CUR = 15'h0002;
	localparam logic [RTCB_AW-1:0] RTCB_DESC_W4 = 15'h0003;
	// mode 1 keeps info and time tag ahead of the data
	localparam logic [RTCB_AW-1:0] RTCB_M1_DATA_OFS = 15'h0002;
	localparam logic [RTCB_AW-1:0] RTCB_TAG_OFS = 15'h0001;
	localparam logic [RTCB_AW-1:0] RTCB_M2_INFO_STEP = 15'h0002;

	// ----------------------------------------------------------------
	// control word fields
	// ----------------------------------------------------------------
	localparam int RTCB_CW_BUF_SEL = 0;
	localparam int RTCB_CW_CIR1 = 1;
	localparam int RTCB_CW_CIR2 = 2;
	localparam int RTCB_CW_PP = 3;
	localparam int RTCB_CW_CODE_LO = 4;
	localparam int RTCB_CW_CODE_HI = 7;
	localparam int RTCB_CW_LIMIT_IRQ = 8;
	localparam int RTCB_INFO_BROADCAST_FLAG_BIT = 9;

	// ----------------------------------------------------------------
	// wishbone register map (byte addresses) and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] RTCB_REG_CONFIG = 4'h0;
	localparam logic [3:0] RTCB_REG_STATUS = 4'h4;
	localparam logic [3:0] RTCB_REG_LAST_PTR = 4'h8;
	localparam int RTCB_CFG_LIMIT_IRQ = 0;
	localparam int RTCB_CFG_BROADCAST_FLAG_SEG = 1;
	localparam logic [1:0] RTCB_CONFIG_RST = 2'h0;
	localparam int RTCB_ST_BUSY = 0;
	localparam int RTCB_ST_MODE2 = 1;
	localparam int RTCB_ST_WRAP = 2;
	localparam int RTCB_ST_CNT_LO = 16;

	// ----------------------------------------------------------------
	// sequencer states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [10:0] {
		RTCB_IDLE = 11'h001,
		RTCB_RD_CTRL = 11'h002,
		RTCB_RD_START = 11'h004,
		RTCB_RD_CUR = 11'h008,
		RTCB_RD_W4 = 11'h010,
		RTCB_WR_INFO = 11'h020,
		RTCB_WR_TAG = 11'h040,
		RTCB_WR_DATA = 11'h080,
		RTCB_WR_CUR = 11'h100,
		RTCB_WR_W4 = 11'h200,
		RTCB_DONE = 11'h400
	} rtcb_state_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [RTCB_AW-1:0] desc_addr;
		logic is_tx;
		logic is_broadcast;
		logic msg_error;
		logic busy_status;
		logic illegal;
		logic [RTCB_WCW-1:0] word_count;
		logic [RTCB_DW-1:0] info_word;
		logic [RTCB_DW-1:0] time_tag;
	} rtcb_msg_t;

	typedef struct packed {
		logic valid;
		logic we;
		logic [RTCB_AW-1:0] addr;
		logic [RTCB_DW-1:0] wdata;
	} rtcb_ram_req_t;

	typedef struct packed {
		logic done;
		logic good;
		logic wrapped;
		logic unsupported;
	} rtcb_result_t;

endpackage

// [test/rtcb_checker.sv]
// rtcb_checker: pointer and sequencing assertions on the engine ports.
// assumes ram read data is valid in the cycle of its ack.
`timescale 1ns/1ps

module rtcb_checker
	import rtcb_pkg::*;
#(
	parameter int MAX_WORDS = rtcb_pkg::RTCB_MAX_WORDS
)
(
	input wire logic mclk, // clock
	input wire logic srst, // reset
	input wire logic msg_valid, // message pulse
	input wire rtcb_pkg::rtcb_msg_t msg_in, // message details
	input wire rtcb_pkg::rtcb_ram_req_t ram_req, // ram request
	input wire logic ram_ack, // ram ack
	input wire logic [rtcb_pkg::RTCB_DW-1:0] ram_rdata, // ram data
	input wire logic busy, // busy
	input wire logic tx_inhibit, // transmit suppressed
	input wire rtcb_pkg::rtcb_result_t result, // outcome
	input wire logic message_interrupt_output // interrupt
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	// --------
	// snapshot of the message and descriptor in flight
	// --------
	rtcb_msg_t m_q;
	logic [15:0] ctrl_q, start_q, cur_q, w4_q;
	wire logic [14:0] ofs = ram_req.addr - m_q.desc_addr;
	wire logic rd = busy && ram_req.valid && ram_ack && !ram_req.we;
	wire logic wr = busy && ram_req.valid && ram_req.we;
	wire logic m1 = ctrl_q[3:1] == 3'h1;
	wire logic m2 = ctrl_q[3:2] == 2'h1;
	wire logic [15:0] wc = {10'h000, m_q.word_count};
	wire logic [15:0] mask = (16'h0001 << ctrl_q[7:4]) - 16'h0001;
	wire logic full = ((w4_q + 16'h0001) & mask) == mask;
	wire logic [15:0] end1 = cur_q + 16'h0002 + wc;
	wire logic [15:0] cur1 = end1 > w4_q ? start_q : end1;
	wire logic [15:0] exp_cur = m2 ? (full ? start_q : cur_q + wc) : cur1;
	wire logic [15:0] exp_w4 = full ? w4_q & ~mask : w4_q + 16'h0002;
	wire logic [14:0] info_a = m2 ? w4_q[14:0] : cur_q[14:0];
	wire logic bad = m_q.msg_error || m_q.busy_status || m_q.illegal
		|| (m_q.is_tx && m_q.is_broadcast);

	always_ff @(posedge mclk)
	begin
		if (msg_valid && !busy)
			m_q <= msg_in;
		if (rd && ofs == RTCB_DESC_CTRL)
			ctrl_q <= ram_rdata;
		if (rd && ofs == RTCB_DESC_START)
			start_q <= ram_rdata;
		if (rd && ofs == RTCB_DESC_CUR)
			cur_q <= ram_rdata;
		if (rd && ofs == RTCB_DESC_W4)
			w4_q <= ram_rdata;
	end

	property p_irq_cause;
		message_interrupt_output |-> result.done && result.wrapped;
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("interrupt without wrapped completion");
	property p_start_read;
		msg_valid && !busy |-> ##[1:3] (ram_req.valid && !ram_req.we
			&& ram_req.addr == m_q.desc_addr);
	endproperty
	a_start_read: assert property (p_start_read)
		else $error("descriptor read missing");
	property p_info_flag;
		wr && ram_req.addr == info_a |->
			ram_req.wdata[RTCB_INFO_BROADCAST_FLAG_BIT] == m_q.is_broadcast;
	endproperty
	a_info_flag: assert property (p_info_flag)
		else $error("info broadcast flag wrong");
	property p_tag_next;
		wr && ram_req.addr == info_a + 15'h0001 |->
			ram_req.wdata == m_q.time_tag;
	endproperty
	a_tag_next: assert property (p_tag_next)
		else $error("time tag wrong");
	property p_bad_keeps;
		wr && bad |-> ofs != RTCB_DESC_CUR && ofs != RTCB_DESC_W4;
	endproperty
	a_bad_keeps: assert property (p_bad_keeps)
		else $error("pointer written for failed message");
	property p_cur_value;
		wr && ofs == RTCB_DESC_CUR |-> ram_req.wdata == exp_cur;
	endproperty
	a_cur_value: assert property (p_cur_value)
		else $error("current pointer value wrong");
	property p_w4_value;
		wr && ofs == RTCB_DESC_W4 |-> m2 && ram_req.wdata == exp_w4;
	endproperty
	a_w4_value: assert property (p_w4_value)
		else $error("info pointer value wrong");
	property p_inhibit;
		tx_inhibit |-> busy && m_q.is_tx && m_q.is_broadcast;
	endproperty
	a_inhibit: assert property (p_inhibit)
		else $error("transmit inhibit without broadcast transmit");
	property p_unsup;
		result.done |-> result.unsupported == !(m1 || m2);
	endproperty
	a_unsup: assert property (p_unsup)
		else $error("mode selection wrong");

	c_wrap: cover property (result.done && result.wrapped);
	c_inhibit: cover property (tx_inhibit);
	c_full: cover property (wr && ofs == RTCB_DESC_W4 && full);
endmodule

bind rtcb_top rtcb_checker #(.MAX_WORDS(MAX_WORDS)) u_chk (.mclk(mclk),
	.srst(srst), .msg_valid(msg_valid), .msg_in(msg_in),
	.ram_req(ram_req), .ram_ack(ram_ack), .ram_rdata(ram_rdata),
	.busy(busy), .tx_inhibit(tx_inhibit), .result(result),
	.message_interrupt_output(message_interrupt_output));

// [test/rtcb_ram_model.sv]
// rtcb_ram_model: shared ram that the host preloads with descriptors.
// assumes the engine holds each request until it sees ack.
`timescale 1ns/1ps

module rtcb_ram_model
	import rtcb_pkg::*;
(
	input wire rtcb_pkg::rtcb_ram_req_t req, // request from the engine
	input wire logic mclk, // device clock
	input wire logic slow, // two wait cycles per access
	output logic ack, // access complete
	output logic [rtcb_pkg::RTCB_DW-1:0] rdata // read data with ack
);
	logic [15:0] mem [0:32767];
	int cnt = 0;

	initial
	begin
		ack = 1'b0;
		rdata = 16'h0000;
		foreach (mem[i])
			mem[i] = 16'h0000;
	end

	// read data is only good in the ack cycle
	always @(posedge mclk)
	begin
		if (ack && req.valid && req.we)
			mem[req.addr] <= req.wdata;
		if (req.valid && !ack && cnt >= (slow ? 2 : 0))
		begin
			ack <= 1'b1;
			rdata <= mem[req.addr];
			cnt <= 0;
		end
		else
		begin
			ack <= 1'b0;
			rdata <= ~rdata;
			cnt <= (req.valid && !ack) ? cnt + 1 : 0;
		end
	end
endmodule

// [test/rtcb_top_tb.sv]
// rtcb_top_tb: directed tests of the circular buffer engine.
// assumes the ram model stands for shared ram and the host.
`timescale 1ns/1ps

module rtcb_top_tb;
	import rtcb_pkg::*;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic msg_valid = 1'b0, rx_word_valid = 1'b0, slow = 1'b0;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [3:0] wb_adr = 4'h0, wb_sel = 4'h0;
	logic [31:0] wb_wd = 32'h0, wb_rd, rd;
	logic [15:0] rx_word = 16'h0, ram_rdata;
	logic ram_ack, busy, tx_inhibit, irq, wb_ack, seen_irq, seen_inh;
	rtcb_msg_t msg = '0;
	rtcb_ram_req_t ram_req;
	rtcb_result_t result, res;
	int n_fail = 0;
	int cmp_count = 0;

	rtcb_top uut (.mclk(mclk), .srst(srst), .msg_valid(msg_valid),
		.msg_in(msg), .rx_word_valid(rx_word_valid), .rx_word(rx_word),
		.ram_req(ram_req), .ram_ack(ram_ack), .ram_rdata(ram_rdata),
		.busy(busy), .tx_inhibit(tx_inhibit), .result(result),
		.message_interrupt_output(irq), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd),
		.wb_ack_o(wb_ack));
	rtcb_ram_model ram (.req(ram_req), .mclk(mclk), .slow(slow),
		.ack(ram_ack), .rdata(ram_rdata));

	initial
	begin
		forever #12.5 mclk = ~mclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		if (n_fail == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wb(input logic we, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hF;
		wb_wd <= d;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (wb_ack !== 1'b1 && n < 50);
		rd = wb_rd;
		n_fail += (n >= 50);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic desc(input logic [14:0] n, input logic [15:0] c, s, p, e);
		ram.mem[n] = c;
		ram.mem[n + 15'h0001] = s;
		ram.mem[n + 15'h0002] = p;
		ram.mem[n + 15'h0003] = e;
	endtask

	task automatic send(input logic [14:0] n, input logic tx, bc,
		input logic [2:0] bad, input logic [5:0] wc, input logic [15:0] tag);
		int k;
		for (k = 0; !tx && k < wc; k++)
		begin
			rx_word_valid <= 1'b1;
			rx_word <= 16'hA000 + 16'(k);
			@(posedge mclk);
		end
		rx_word_valid <= 1'b0;
		msg <= '{n, tx, bc, bad[2], bad[1], bad[0], wc, 16'h0201, tag};
		msg_valid <= 1'b1;
		@(posedge mclk);
		msg_valid <= 1'b0;
		seen_irq = 1'b0;
		seen_inh = 1'b0;
		k = 0;
		do
		begin
			@(posedge mclk);
			k++;
			seen_inh |= tx_inhibit === 1'b1;
			seen_irq |= irq === 1'b1;
		end
		while (result.done !== 1'b1 && k < 500);
		res = result;
		n_fail += (k >= 500);
		@(posedge mclk);
	endtask

	task automatic t_regs;
		wb(1'b0, RTCB_REG_CONFIG, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, RTCB_REG_CONFIG, 32'h3);
		wb(1'b0, RTCB_REG_CONFIG, 32'h0);
		chk(rd, 32'h3);
		wb(1'b0, 4'hC, 32'h0);
		chk(rd, 32'h0);
	endtask

	task automatic t_mode1;
		desc(15'h0100, 16'h0102, 16'h0200, 16'h0200, 16'h020F);
		send(15'h0100, 1'b0, 1'b1, 3'h0, 6'h04, 16'h1111);
		chk(res, 4'hC);
		chk(ram.mem[15'h0200], 16'h0201);
		for (int k = 0; k < 4; k++)
			chk(ram.mem[15'h0202 + k], 16'hA000 + k);
		chk(ram.mem[15'h0102], 16'h0206);
		send(15'h0100, 1'b0, 1'b0, 3'h0, 6'h08, 16'h2222);
		chk({res, seen_irq}, 5'h1D);
		chk({ram.mem[15'h0206], ram.mem[15'h0102]}, 32'h00010200);
		send(15'h0100, 1'b0, 1'b0, 3'h0, 6'h0D, 16'h3333);
		chk(ram.mem[15'h0102], 16'h020F);
		wb(1'b1, RTCB_REG_CONFIG, 32'h2);
		send(15'h0100, 1'b0, 1'b0, 3'h0, 6'h01, 16'h4444);
		chk({res, seen_irq}, 5'h1C);
		chk({ram.mem[15'h0211], ram.mem[15'h0102]}, 32'hA0000200);
		chk(ram.mem[15'h0210], 16'h4444);
	endtask

	task automatic t_broadcast_flag_tx;
		desc(15'h0110, 16'h0002, 16'h0300, 16'h0300, 16'h033F);
		send(15'h0110, 1'b1, 1'b1, 3'h0, 6'h02, 16'h5555);
		chk({seen_inh, ram.mem[15'h0112]}, 17'h10300);
		chk(ram.mem[15'h0301], 16'h5555);
		send(15'h0110, 1'b1, 1'b0, 3'h0, 6'h02, 16'h6666);
		chk({seen_inh, ram.mem[15'h0300]}, 17'h00001);
		chk({ram.mem[15'h0301], ram.mem[15'h0112]}, 32'h66660304);
	endtask

	task automatic t_mode2;
		wb(1'b1, RTCB_REG_CONFIG, 32'h1);
		desc(15'h0120, 16'h0127, 16'h0400, 16'h0400, 16'h0600);
		desc(15'h0130, 16'h0024, 16'h0500, 16'h0500, 16'h0700);
		send(15'h0120, 1'b0, 1'b0, 3'h0, 6'h02, 16'h7000);
		chk(res, 4'hC);
		chk({ram.mem[15'h0600], ram.mem[15'h0601]}, 32'h00017000);
		chk({ram.mem[15'h0400], ram.mem[15'h0401]}, 32'hA000A001);
		chk({ram.mem[15'h0122], ram.mem[15'h0123]}, 32'h04020602);
		send(15'h0130, 1'b1, 1'b0, 3'h0, 6'h03, 16'h7100);
		chk({ram.mem[15'h0132], ram.mem[15'h0133]}, 32'h05030702);
		chk(ram.mem[15'h0701], 16'h7100);
		for (int k = 0; k < 3; k++)
		begin
			send(15'h0120, 1'b0, 1'b0, 3'(1 << k), 6'h02,
				16'h7200 + 16'(k));
			chk(ram.mem[15'h0603], 16'h7200 + k);
			chk({ram.mem[15'h0122], ram.mem[15'h0123]}, 32'h04020602);
		end
		chk(ram.mem[15'h0402], 16'h0000);
		send(15'h0120, 1'b0, 1'b1, 3'h0, 6'h02, 16'h7300);
		chk({res, seen_irq}, 5'h1D);
		chk({ram.mem[15'h0602], ram.mem[15'h0603]}, 32'h02017300);
		chk({ram.mem[15'h0402], ram.mem[15'h0403]}, 32'hA000A001);
		chk({ram.mem[15'h0122], ram.mem[15'h0123]}, 32'h04000600);
		// eight good messages so far, last one mode 2 and wrapped
		wb(1'b0, RTCB_REG_STATUS, 32'h0);
		chk(rd, 32'h00080006);
		wb(1'b0, RTCB_REG_LAST_PTR, 32'h0);
		chk(rd, 32'h04000600);
		chk(busy, 32'h0);
	endtask

	task automatic t_unsup;
		logic [15:0] c [3] = '{16'h0000, 16'h0008, 16'h000C};
		for (int k = 0; k < 3; k++)
		begin
			desc(15'h0140, c[k], 16'h0800, 16'h0800, 16'h0900);
			send(15'h0140, 1'b0, 1'b0, 3'h0, 6'h01, 16'h7400);
			chk({res.done, res.unsupported}, 2'h3);
			chk(ram.mem[15'h0142], 16'h0800);
		end
	endtask

	initial
	begin
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		t_regs();
		t_mode1();
		t_broadcast_flag_tx();
		slow <= 1'b1;
		t_mode2();
		t_unsup();
		final_report();
	end

	initial
	begin
		#500000;
		n_fail++;
		final_report();
	end
endmodule
